// ---- verilog/stm_pkg.sv ----
// Operation
// - Line period is a 16-bit count of crystal clocks taken across sixteen back-to-back line sync periods.
// - Both line measurements carry four fractional low bits, so each reads as one period or pulse in 1/16 clock.
// - Line pulse width is a 16-bit count of crystal clocks summed over sixteen pulses, read as high and low bytes.
// - Frame period is a 12-bit value spanning two fields when interlaced and one field when progressive.
// - The frame period upper nibble sits in bits 3:0 of its high byte and the lower eight bits in its low byte.
// - Frame pulse width is a 7-bit value of the true frame pulse only, ignoring serration and equalizing pulses.
// - Unit-select 0 reports vertical figures in line periods, 1 reports them in units of 512 crystal clocks.
// - Method bit 0 counts whole line sync pulses, method bit 1 uses a timed line measurement that may round.
// - The first valid pixel lies a programmed pixel count after the line sync trailing edge, high part in 1:0.
// - Visible pixels per line are a 12-bit value resetting to high nibble 0x05 and low byte 0x00.
// - The first valid line lies a programmed line count after the frame sync trailing edge, low byte 0x26.
// - Visible lines are a 12-bit value resetting to high nibble 0x04 and low byte 0x00.
// - A command write starts the code in bits 2:0, 011 phase search and 100 window detect; others are not written.
// - Status bit 7 reads 1 while an adjust command runs and 0 when the adjust function is idle.
// - Per-input kind bits (4 for input 0, 5 for input 1) select polling of all sync types at 0 or green-only at 1.
package stm_pkg;
  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_HP_HI   = 8'h40;
  localparam logic [7:0] IDX_HP_LO   = 8'h41;
  localparam logic [7:0] IDX_HW_HI   = 8'h42;
  localparam logic [7:0] IDX_HW_LO   = 8'h43;
  localparam logic [7:0] IDX_FP_HI   = 8'h44;
  localparam logic [7:0] IDX_FP_LO   = 8'h45;
  localparam logic [7:0] IDX_VW      = 8'h46;
  localparam logic [7:0] IDX_PS_HI   = 8'h47;
  localparam logic [7:0] IDX_PS_LO   = 8'h48;
  localparam logic [7:0] IDX_PC_HI   = 8'h49;
  localparam logic [7:0] IDX_PC_LO   = 8'h4A;
  localparam logic [7:0] IDX_LS_HI   = 8'h4B;
  localparam logic [7:0] IDX_LS_LO   = 8'h4C;
  localparam logic [7:0] IDX_LC_HI   = 8'h4D;
  localparam logic [7:0] IDX_LC_LO   = 8'h4E;
  localparam logic [7:0] IDX_CFG     = 8'h4F;
  localparam logic [7:0] IDX_CMD     = 8'h50;
  localparam logic [7:0] IDX_STAT    = 8'h51;
  localparam logic [7:0] IDX_POLL    = 8'h32;
  localparam logic [7:0] IDX_IRQ_ST  = 8'h5C;
  localparam logic [7:0] IDX_IRQ_MSK = 8'h5D;
  // reset values of the window registers
  localparam logic [9:0]  PS_RST = 10'h0F6;
  localparam logic [11:0] PC_RST = 12'h500;
  localparam logic [9:0]  LS_RST = 10'h026;
  localparam logic [11:0] LC_RST = 12'h400;
  // field positions
  localparam int CFG_UNIT_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam int POLL_K0_BIT  = 4;
  localparam int POLL_K1_BIT  = 5;
  localparam int STAT_BUSY    = 7;
  localparam int FRAC_BITS    = 4;
  // measurement geometry
  localparam logic [3:0]  LINE_WIN_LAST = 4'hF;
  localparam logic [8:0]  XTAL_DIV_LAST = 9'h1FF;
  // adjust command codes
  localparam logic [2:0] CMD_PHASE  = 3'h3;
  localparam logic [2:0] CMD_WINDOW = 3'h4;
  // sticky event bits
  localparam int IRQ_LINE  = 0;
  localparam int IRQ_FRAME = 1;
  localparam int IRQ_CMD   = 2;
  localparam int IRQ_W     = 3;
  // poll enables, {green, composite, line}
  localparam logic [2:0] POLL_ALL   = 3'h7;
  localparam logic [2:0] POLL_GREEN = 3'h4;
endpackage : stm_pkg

// ---- verilog/stm_top.sv ----
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
module stm_top #(
  parameter int          ADR_W      = 10,
  parameter logic [3:0]  ADJ_FRAMES = 4'h4
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              line_sync_output_i,
  input  wire logic              frame_sync_output_i,
  output logic                   active_pixel_window_o,
  output logic                   run_phase_search_o,
  output logic                   run_window_detect_o,
  output logic      [2:0]        input0_poll_o,
  output logic      [2:0]        input1_poll_o,
  output logic                   irq_o
);
  import stm_pkg::*;

  typedef struct packed {
    logic               ack;
    logic [31:0]        rdata;
    logic               line_prev;
    logic               frame_prev;
    logic [15:0]        hp_acc;
    logic [3:0]         hp_cnt;
    logic [15:0]        hp_res;
    logic [15:0]        hw_acc;
    logic [3:0]         hw_cnt;
    logic [15:0]        hw_res;
    logic               hp_armed;
    logic               hw_armed;
    logic [11:0]        ln_clk;
    logic [11:0]        t_clk;
    logic [8:0]         pre;
    logic [11:0]        fp_acc;
    logic [6:0]         vw_acc;
    logic [11:0]        fp_res;
    logic [6:0]         vw_res;
    logic               f_armed;
    logic               half_prev;
    logic               interlaced;
    logic               field_odd;
    logic [9:0]         ps;
    logic [11:0]        pc;
    logic [9:0]         ls;
    logic [11:0]        lc;
    logic [1:0]         cfg;
    logic [1:0]         kind;
    logic [2:0]         cmd;
    logic               busy;
    logic [3:0]         run_left;
    logic               phase_run;
    logic               detect_run;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_msk;
    logic               irq;
    logic [11:0]        pix_pos;
    logic [11:0]        line_pos;
    logic               window;
    logic [2:0]         poll0;
    logic [2:0]         poll1;
  } stm_state_t;

  stm_state_t s_reg;
  stm_state_t s_next;

  logic [7:0] idx;
  logic       req;
  logic       wr;
  logic       line_rise;
  logic       line_fall;
  logic       frame_rise;
  logic       frame_fall;
  logic       vtick;
  logic       close_frame;
  logic       half_now;
  logic [IRQ_W-1:0] ev;
  logic [7:0] rbyte;
  logic [15:0] hp_sum;
  logic [15:0] hw_sum;

  // index taken from the word address; low two bits are the byte in word
  assign idx        = wb_adr_i[9:2];
  assign req        = wb_cyc_i & wb_stb_i;
  assign wr         = req & wb_we_i & s_reg.ack & wb_sel_i[0];
  assign line_rise  = line_sync_output_i & ~s_reg.line_prev;
  assign line_fall  = ~line_sync_output_i & s_reg.line_prev;
  assign frame_rise = frame_sync_output_i & ~s_reg.frame_prev;
  assign frame_fall = ~frame_sync_output_i & s_reg.frame_prev;

  // vertical time base: line pulses, timed lines, or 512-clock ticks
  always_comb begin
    if (s_reg.cfg[CFG_UNIT_BIT]) begin
      vtick = (s_reg.pre == XTAL_DIV_LAST);
    end else if (s_reg.cfg[CFG_MODE_BIT]) begin
      vtick = (s_reg.hp_res[15:FRAC_BITS] != 12'h000) &&
              (s_reg.t_clk >= s_reg.hp_res[15:FRAC_BITS] - 12'h001);
    end else begin
      vtick = line_rise;
    end
  end

  // field phase against the line: a half-line offset marks interlace
  // no phase can be judged before a line period has been published
  assign half_now    = (s_reg.hp_res[15:5] != 11'h000) && (s_reg.ln_clk > {1'b0, s_reg.hp_res[15:5]});
  assign close_frame = frame_rise & (~s_reg.interlaced | s_reg.field_odd);

  // readback mux, narrow registers sit in the low bits except busy (bit 7) and kind (bits 5:4)
  always_comb begin
    case (idx)
      IDX_HP_HI:   rbyte = s_reg.hp_res[15:8];
      IDX_HP_LO:   rbyte = s_reg.hp_res[7:0];
      IDX_HW_HI:   rbyte = s_reg.hw_res[15:8];
      IDX_HW_LO:   rbyte = s_reg.hw_res[7:0];
      IDX_FP_HI:   rbyte = {4'h0, s_reg.fp_res[11:8]};
      IDX_FP_LO:   rbyte = s_reg.fp_res[7:0];
      IDX_VW:      rbyte = {1'b0, s_reg.vw_res};
      IDX_PS_HI:   rbyte = {6'h00, s_reg.ps[9:8]};
      IDX_PS_LO:   rbyte = s_reg.ps[7:0];
      IDX_PC_HI:   rbyte = {4'h0, s_reg.pc[11:8]};
      IDX_PC_LO:   rbyte = s_reg.pc[7:0];
      IDX_LS_HI:   rbyte = {6'h00, s_reg.ls[9:8]};
      IDX_LS_LO:   rbyte = s_reg.ls[7:0];
      IDX_LC_HI:   rbyte = {4'h0, s_reg.lc[11:8]};
      IDX_LC_LO:   rbyte = s_reg.lc[7:0];
      IDX_CFG:     rbyte = {6'h00, s_reg.cfg};
      IDX_CMD:     rbyte = {5'h00, s_reg.cmd};
      IDX_STAT:    rbyte = {s_reg.busy, 7'h00};
      IDX_POLL:    rbyte = {2'h0, s_reg.kind, 4'h0};
      IDX_IRQ_ST:  rbyte = {5'h00, s_reg.irq_st};
      IDX_IRQ_MSK: rbyte = {5'h00, s_reg.irq_msk};
      default:     rbyte = 8'h00;
    endcase
  end

  // saturating sums; a stopped sync must not wrap into a small value
  assign hp_sum = (s_reg.hp_acc == 16'hFFFF) ? 16'hFFFF : s_reg.hp_acc + 16'h0001;
  assign hw_sum = (s_reg.hw_acc == 16'hFFFF) ? 16'hFFFF : s_reg.hw_acc + 16'h0001;

  // next-state logic for the whole block
  always_comb begin
    s_next            = s_reg;
    ev                = '0;
    s_next.line_prev  = line_sync_output_i;
    s_next.frame_prev = frame_sync_output_i;

    // wishbone classic: ack one cycle after the request, then drop
    s_next.ack   = req & ~s_reg.ack;
    s_next.rdata = (req & ~s_reg.ack) ? {24'h000000, rbyte} : 32'h0000_0000;

    // line period over sixteen rising-edge intervals
    s_next.hp_acc = hp_sum;
    if (line_rise) begin
      s_next.hp_armed = 1'b1;
      if (!s_reg.hp_armed) begin
        s_next.hp_acc = 16'h0001;
        s_next.hp_cnt = 4'h0;
      end else if (s_reg.hp_cnt == LINE_WIN_LAST) begin
        s_next.hp_res = s_reg.hp_acc;
        s_next.hp_acc = 16'h0001;
        s_next.hp_cnt = 4'h0;
        ev[IRQ_LINE]  = 1'b1;
      end else begin
        s_next.hp_cnt = s_reg.hp_cnt + 4'h1;
      end
    end

    // line pulse width summed over sixteen pulses
    // the arming edge itself is counted, so the first pulse is summed whole
    if (line_sync_output_i & (s_reg.hw_armed | line_rise)) begin
      s_next.hw_acc = hw_sum;
    end
    if (line_rise) begin
      s_next.hw_armed = 1'b1;
    end
    if (line_fall & s_reg.hw_armed) begin
      if (s_reg.hw_cnt == LINE_WIN_LAST) begin
        s_next.hw_res = s_reg.hw_acc;
        s_next.hw_acc = 16'h0000;
        s_next.hw_cnt = 4'h0;
      end else begin
        s_next.hw_cnt = s_reg.hw_cnt + 4'h1;
      end
    end

    // clocks within a line and within a timed line
    s_next.ln_clk = line_rise ? 12'h000 : ((s_reg.ln_clk == 12'hFFF) ? 12'hFFF : s_reg.ln_clk + 12'h001);
    s_next.t_clk  = vtick ? 12'h000 : ((s_reg.t_clk == 12'hFFF) ? 12'hFFF : s_reg.t_clk + 12'h001);
    s_next.pre    = s_reg.pre + 9'h001;

    // frame period and true frame pulse width
    if (vtick && s_reg.fp_acc != 12'hFFF) begin
      s_next.fp_acc = s_reg.fp_acc + 12'h001;
    end
    if (vtick && frame_sync_output_i && s_reg.vw_acc != 7'h7F) begin
      s_next.vw_acc = s_reg.vw_acc + 7'h01;
    end
    if (frame_rise) begin
      s_next.f_armed    = 1'b1;
      s_next.half_prev  = half_now;
      s_next.interlaced = (half_now != s_reg.half_prev);
      s_next.field_odd  = ~s_reg.field_odd;
      s_next.vw_acc     = 7'h00;
    end
    if (close_frame) begin
      if (s_reg.f_armed) begin
        s_next.fp_res    = s_reg.fp_acc;
        ev[IRQ_FRAME]    = 1'b1;
      end
      s_next.fp_acc    = 12'h000;
      s_next.field_odd = 1'b0;
    end
    // serrations sit inside the pulse; width is taken at its trailing edge
    if (frame_fall & s_reg.f_armed) begin
      s_next.vw_res = s_reg.vw_acc;
    end

    // active window counters, one clock per pixel
    s_next.pix_pos = line_fall ? 12'h000 : ((s_reg.pix_pos == 12'hFFF) ? 12'hFFF : s_reg.pix_pos + 12'h001);
    if (frame_fall) begin
      s_next.line_pos = 12'h000;
    end else if (line_fall && s_reg.line_pos != 12'hFFF) begin
      s_next.line_pos = s_reg.line_pos + 12'h001;
    end
    s_next.window = (s_reg.pix_pos >= {2'h0, s_reg.ps}) &&
                    (s_reg.pix_pos - {2'h0, s_reg.ps} < s_reg.pc) &&
                    (s_reg.line_pos >= {2'h0, s_reg.ls}) &&
                    (s_reg.line_pos - {2'h0, s_reg.ls} < s_reg.lc);

    // poll selection per input
    s_next.poll0 = s_reg.kind[0] ? POLL_GREEN : POLL_ALL;
    s_next.poll1 = s_reg.kind[1] ? POLL_GREEN : POLL_ALL;

    // adjust command runs for a number of frame edges
    if (s_reg.busy && frame_rise) begin
      if (s_reg.run_left <= 4'h1) begin
        s_next.busy       = 1'b0;
        s_next.run_left   = 4'h0;
        s_next.phase_run  = 1'b0;
        s_next.detect_run = 1'b0;
        ev[IRQ_CMD]       = 1'b1;
      end else begin
        s_next.run_left = s_reg.run_left - 4'h1;
      end
    end

    // register writes at the acknowledging edge
    if (wr) begin
      case (idx)
        IDX_PS_HI:   s_next.ps[9:8]  = wb_dat_i[1:0];
        IDX_PS_LO:   s_next.ps[7:0]  = wb_dat_i[7:0];
        IDX_PC_HI:   s_next.pc[11:8] = wb_dat_i[3:0];
        IDX_PC_LO:   s_next.pc[7:0]  = wb_dat_i[7:0];
        IDX_LS_HI:   s_next.ls[9:8]  = wb_dat_i[1:0];
        IDX_LS_LO:   s_next.ls[7:0]  = wb_dat_i[7:0];
        IDX_LC_HI:   s_next.lc[11:8] = wb_dat_i[3:0];
        IDX_LC_LO:   s_next.lc[7:0]  = wb_dat_i[7:0];
        IDX_CFG:     s_next.cfg      = wb_dat_i[1:0];
        IDX_POLL:    s_next.kind     = {wb_dat_i[POLL_K1_BIT], wb_dat_i[POLL_K0_BIT]};
        IDX_IRQ_MSK: s_next.irq_msk  = wb_dat_i[IRQ_W-1:0];
        IDX_CMD: begin
          // reserved codes and writes while busy change nothing
          if (!s_reg.busy && (wb_dat_i[2:0] == CMD_PHASE || wb_dat_i[2:0] == CMD_WINDOW)) begin
            s_next.cmd        = wb_dat_i[2:0];
            s_next.busy       = 1'b1;
            s_next.run_left   = ADJ_FRAMES;
            s_next.phase_run  = (wb_dat_i[2:0] == CMD_PHASE);
            s_next.detect_run = (wb_dat_i[2:0] == CMD_WINDOW);
          end
        end
        default: ;
      endcase
    end

    // sticky events: a new event wins over a write-one clear
    s_next.irq_st = s_reg.irq_st;
    if (wr && idx == IDX_IRQ_ST) begin
      s_next.irq_st = s_reg.irq_st & ~wb_dat_i[IRQ_W-1:0];
    end
    s_next.irq_st = s_next.irq_st | ev;
    s_next.irq    = |(s_next.irq_st & s_next.irq_msk);
  end

  // state register with synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg      <= '0;
      s_reg.ps   <= PS_RST;
      s_reg.pc   <= PC_RST;
      s_reg.ls   <= LS_RST;
      s_reg.lc   <= LC_RST;
      s_reg.poll0 <= POLL_ALL;
      s_reg.poll1 <= POLL_ALL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_ack_o              = s_reg.ack;
  assign wb_dat_o              = s_reg.rdata;
  assign active_pixel_window_o = s_reg.window;
  assign run_phase_search_o    = s_reg.phase_run;
  assign run_window_detect_o   = s_reg.detect_run;
  assign input0_poll_o         = s_reg.poll0;
  assign input1_poll_o         = s_reg.poll1;
  assign irq_o                 = s_reg.irq;

  // checks on the block's own behaviour
  line_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_rise && s_reg.hp_armed && s_reg.hp_cnt == 4'hF |=> s_reg.hp_res == $past(s_reg.hp_acc))
    else $error("line period not published at end of window");
  line_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(line_rise && s_reg.hp_cnt == 4'hF) |=> $stable(s_reg.hp_res))
    else $error("line period changed mid window");
  width_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_sync_output_i && s_reg.hw_armed && s_reg.hw_acc < 16'hFFFF && !(line_fall)
    |=> s_reg.hw_acc == $past(s_reg.hw_acc) + 16'h0001)
    else $error("pulse width sum did not grow");
  frame_hi_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !s_reg.ack && idx == IDX_FP_HI |=> wb_dat_o[31:4] == 28'h0000000)
    else $error("frame period high byte has upper bits set");
  vw_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !s_reg.ack && idx == IDX_VW |=> wb_dat_o[7] == 1'b0)
    else $error("frame pulse width wider than seven bits");
  unit_tick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.cfg[CFG_UNIT_BIT] && s_reg.pre != 9'h1FF && !frame_rise |=> s_reg.fp_acc == $past(s_reg.fp_acc))
    else $error("frame count moved between 512-clock ticks");
  busy_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CMD && !s_reg.busy && wb_dat_i[2:0] == CMD_WINDOW |=> s_reg.busy && s_reg.detect_run)
    else $error("busy not raised on accepted command");
  busy_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CMD && s_reg.busy |=> $stable(s_reg.cmd))
    else $error("command taken while busy");
  status_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !s_reg.ack && idx == IDX_STAT |=> wb_dat_o[7] == $past(s_reg.busy))
    else $error("status bit 7 does not follow busy");
  poll_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.kind[0] |=> input0_poll_o == 3'h4)
    else $error("green-only polling not selected");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
  window_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.pix_pos < {2'h0, s_reg.ps} |=> !active_pixel_window_o)
    else $error("window open before first pixel");
  width_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    line_fall && s_reg.hw_armed && s_reg.hw_cnt == 4'hF |=> s_reg.hw_res == $past(s_reg.hw_acc))
    else $error("pulse width not published at end of window");
  frame_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(close_frame && s_reg.f_armed) |=> $stable(s_reg.fp_res))
    else $error("frame period changed mid frame");
  cmd_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.busy && frame_rise && s_reg.run_left <= 4'h1 |=> !s_reg.busy && !run_phase_search_o && !run_window_detect_o)
    else $error("busy not dropped at end of command");
  reserved_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_CMD && !s_reg.busy && wb_dat_i[2:0] != CMD_PHASE && wb_dat_i[2:0] != CMD_WINDOW |=> !s_reg.busy)
    else $error("reserved command started a run");
  poll_kind1_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.kind[1] |=> input1_poll_o == 3'h4)
    else $error("green-only polling not selected on input 1");
  sticky_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev[IRQ_CMD] |=> s_reg.irq_st[IRQ_CMD])
    else $error("command done event lost");
endmodule : stm_top

// ---- testbench/stm_sync_source.sv ----
`timescale 1ns/10ps
module stm_sync_source #(
  parameter int LINE_P  = 20,
  parameter int LINE_W  = 4,
  parameter int FRAME_L = 10,
  parameter int FRAME_W = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      line_sync_o,
  output logic      frame_sync_o
);
  int pix_cnt;
  int line_cnt;
  int pos;
  // raster counters; the source stands still and low while switched off
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pix_cnt  <= 0;
      line_cnt <= 0;
    end else if (pix_cnt == LINE_P - 1) begin
      pix_cnt  <= 0;
      line_cnt <= (line_cnt == FRAME_L - 1) ? 0 : line_cnt + 1;
    end else begin
      pix_cnt <= pix_cnt + 1;
    end
  end
  // frame pulse starts off a line edge so it spans exactly FRAME_W line edges
  assign pos          = line_cnt * LINE_P + pix_cnt;
  assign line_sync_o  = run_i && (pix_cnt < LINE_W);
  assign frame_sync_o = run_i && (pos >= 3) && (pos < 3 + FRAME_W * LINE_P);
endmodule : stm_sync_source

// ---- testbench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import stm_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        line_sync_output_i;
  logic        frame_sync_output_i;
  logic        active_pixel_window_o;
  logic        run_phase_search_o;
  logic        run_window_detect_o;
  logic [2:0]  input0_poll_o;
  logic [2:0]  input1_poll_o;
  logic        irq_o;
  logic        sync_run;
  logic [7:0]  rd;
  int          fail_count;
  int          checks_done;

  // short command length keeps each busy span to one frame
  stm_top #(.ADR_W(10), .ADJ_FRAMES(4'h1)) stm_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .line_sync_output_i(line_sync_output_i),
    .frame_sync_output_i(frame_sync_output_i), .active_pixel_window_o(active_pixel_window_o),
    .run_phase_search_o(run_phase_search_o), .run_window_detect_o(run_window_detect_o),
    .input0_poll_o(input0_poll_o), .input1_poll_o(input1_poll_o), .irq_o(irq_o));

  // 20-clock lines, 4-clock pulses, 10 lines a frame, 2-line frame pulse
  stm_sync_source stm_sync_source_inst (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(sync_run),
    .line_sync_o(line_sync_output_i), .frame_sync_o(frame_sync_output_i));

  // clock of 8 ns
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; ack is seen at the edge before its own update lands
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    if (n >= 50) begin
      check("bus ack", 8'h01, 8'h00);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    wb_xfer(1'b1, idx, wd);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), exp, rd);
  endtask : rd_chk

  // port levels are read at the second falling edge, at least half a cycle after the edge that sets them
  task automatic pin_chk(input string what, input logic [7:0] exp);
    logic [7:0] got;
    repeat (2) @(negedge clk_i);
    case (what)
      "poll0":      got = {5'h00, input0_poll_o};
      "poll1":      got = {5'h00, input1_poll_o};
      "phase run":  got = {7'h00, run_phase_search_o};
      "detect run": got = {7'h00, run_window_detect_o};
      "window":     got = {7'h00, active_pixel_window_o};
      default:      got = {7'h00, irq_o};
    endcase
    check(what, exp, got);
  endtask : pin_chk

  // polls status; a stuck busy shows up in the following status compare
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb_xfer(1'b0, IDX_STAT, 8'h00);
      n++;
    end while (rd[7] !== 1'b0 && n < 200);
  endtask : wait_idle

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  // all tests take under 10000 cycles; a hang ends the run as a failure
  initial begin
    repeat (40000) @(posedge clk_i);
    check("watchdog", 8'h01, 8'h00);
    results();
  end

  initial begin
    rst_i       = 1'b1;
    wb_cyc_i    = 1'b0;
    wb_stb_i    = 1'b0;
    wb_we_i     = 1'b0;
    wb_adr_i    = 10'h000;
    wb_sel_i    = 4'hF;
    wb_dat_i    = 32'h00000000;
    sync_run    = 1'b0;
    fail_count  = 0;
    checks_done = 0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(IDX_PS_HI, 8'h00);
    rd_chk(IDX_PS_LO, 8'hF6);
    rd_chk(IDX_PC_HI, 8'h05);
    rd_chk(IDX_PC_LO, 8'h00);
    rd_chk(IDX_LS_LO, 8'h26);
    rd_chk(IDX_LC_HI, 8'h04);
    rd_chk(IDX_LC_LO, 8'h00);
    rd_chk(IDX_CMD, 8'h00);
    rd_chk(IDX_STAT, 8'h00);
    rd_chk(IDX_HP_HI, 8'h00);
    $display("test reset_values done");
    // field widths, read-only and unmapped places
    wr(IDX_PS_HI, 8'hFF);
    rd_chk(IDX_PS_HI, 8'h03);
    wr(IDX_PS_LO, 8'h5A);
    rd_chk(IDX_PS_LO, 8'h5A);
    wr(IDX_PC_HI, 8'hFF);
    rd_chk(IDX_PC_HI, 8'h0F);
    wr(IDX_LC_HI, 8'hFF);
    rd_chk(IDX_LC_HI, 8'h0F);
    wr(IDX_HP_LO, 8'hAA);
    rd_chk(IDX_HP_LO, 8'h00);
    rd_chk(8'h60, 8'h00);
    $display("test register_access done");
    pin_chk("poll0", 8'h07);
    wr(IDX_POLL, 8'h10);
    pin_chk("poll0", 8'h04);
    pin_chk("poll1", 8'h07);
    wr(IDX_POLL, 8'h20);
    pin_chk("poll0", 8'h07);
    pin_chk("poll1", 8'h04);
    $display("test polling done");
    // 16 periods of 20 clocks = 0x140, 16 pulses of 4 clocks = 0x40
    @(posedge clk_i);
    sync_run <= 1'b1;
    repeat (800) @(posedge clk_i);
    rd_chk(IDX_HP_HI, 8'h01);
    rd_chk(IDX_HP_LO, 8'h40);
    rd_chk(IDX_HW_HI, 8'h00);
    rd_chk(IDX_HW_LO, 8'h40);
    rd_chk(IDX_FP_HI, 8'h00);
    rd_chk(IDX_FP_LO, 8'h0A);
    rd_chk(IDX_VW, 8'h02);
    wr(IDX_CFG, 8'h02);
    repeat (600) @(posedge clk_i);
    rd_chk(IDX_FP_LO, 8'h0A);
    // a 200-clock frame holds at most one 512-clock tick; this schedule puts one in the frame read back
    wr(IDX_CFG, 8'h01);
    repeat (600) @(posedge clk_i);
    rd_chk(IDX_FP_LO, 8'h01);
    wr(IDX_CFG, 8'h00);
    $display("test measurement done");
    // every code; writes start just after a frame edge so busy outlasts the reads
    for (int c = 0; c < 8; c++) begin
      @(posedge frame_sync_output_i);
      wr(IDX_CMD, 8'(c));
      pin_chk("phase run", {7'h00, c == 3});
      pin_chk("detect run", {7'h00, c == 4});
      if (c == 3) begin
        wr(IDX_CMD, 8'h04);
        pin_chk("detect run", 8'h00);
      end
      rd_chk(IDX_STAT, (c == 3 || c == 4) ? 8'h80 : 8'h00);
      wait_idle();
      rd_chk(IDX_STAT, 8'h00);
      pin_chk("phase run", 8'h00);
    end
    $display("test commands done");
    // window of pixels 2..4 after the line sync trailing edge, every line
    wr(IDX_PS_HI, 8'h00);
    wr(IDX_PS_LO, 8'h02);
    wr(IDX_PC_HI, 8'h00);
    wr(IDX_PC_LO, 8'h03);
    wr(IDX_LS_LO, 8'h00);
    // a write without the low byte lane must leave the register alone
    wb_sel_i <= 4'hE;
    wr(IDX_PS_LO, 8'h77);
    wb_sel_i <= 4'hF;
    rd_chk(IDX_PS_LO, 8'h02);
    @(negedge line_sync_output_i);
    pin_chk("window", 8'h00);
    pin_chk("window", 8'h00);
    pin_chk("window", 8'h01);
    pin_chk("window", 8'h00);
    $display("test window done");
    // sticky events, mask and write-one-to-clear
    rd_chk(IDX_IRQ_ST, 8'h07);
    pin_chk("irq", 8'h00);
    wr(IDX_IRQ_MSK, 8'h04);
    pin_chk("irq", 8'h01);
    wr(IDX_IRQ_ST, 8'h04);
    pin_chk("irq", 8'h00);
    rd_chk(IDX_IRQ_ST, 8'h03);
    $display("test interrupt done");
    results();
  end
endmodule : testbench
